// ---- inc/scs_pkg.sv ----
// Constants for the serial control sequencer: port addresses, word layouts.
// Assumes an 8-bit host I/O bus with synchronous, one-cycle strobes.
package scs_pkg;

  // ----------------------------------------
  // Port addresses
  // ----------------------------------------
  localparam logic [7:0] DATA_ADDR0 = 8'hEC;
  localparam logic [7:0] CTRL_ADDR0 = 8'hED;
  localparam logic [7:0] DATA_ADDR1 = 8'hEE;
  localparam logic [7:0] CTRL_ADDR1 = 8'hEF;

  // ----------------------------------------
  // Mode word fields
  // ----------------------------------------
  localparam int MODE_BAUD_LSB = 0;
  localparam int MODE_LEN_LSB = 2;
  localparam int MODE_PAR_EN = 4;
  localparam int MODE_PAR_EVEN = 5;
  localparam int MODE_EXT_SYNC = 6;
  localparam int MODE_SINGLE_SYNC = 7;
  localparam int MODE_STOP_LSB = 6;
  localparam logic [1:0] BAUD_SYNC = 2'h0;
  localparam logic [1:0] BAUD_X1 = 2'h1;
  localparam logic [1:0] BAUD_X16 = 2'h2;
  localparam logic [1:0] BAUD_X64 = 2'h3;

  // ----------------------------------------
  // Command word bits
  // ----------------------------------------
  localparam int CMD_TX_EN = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RX_EN = 2;
  localparam int CMD_BREAK = 3;
  localparam int CMD_ERR_RST = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_INT_RESET = 6;
  localparam int CMD_HUNT = 7;

  // ----------------------------------------
  // Status bits and reset values
  // ----------------------------------------
  localparam int STAT_TX_RDY = 0;
  localparam int STAT_RX_RDY = 1;
  localparam int STAT_TX_EMPTY = 2;
  localparam int STAT_PAR_ERR = 3;
  localparam int STAT_OVR_ERR = 4;
  localparam int STAT_FRM_ERR = 5;
  localparam int STAT_SYNDET = 6;
  localparam int STAT_DSR = 7;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam int TX_FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    SEQ_MODE,
    SEQ_SYNC1,
    SEQ_SYNC2,
    SEQ_CMD
  } scs_seq_type;

endpackage

// ---- rtl/scs_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; output data is read straight from the array.
`timescale 1ns/1ps
`default_nettype none
module scs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
  wire [PW-1:0] nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;

  assign in_ready = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= nxt_wr_ptr;
      if (pop) rd_ptr_ff <= nxt_rd_ptr;
      if (push && !pop) count_ff <= count_ff + 1'b1;
      else if (pop && !push) count_ff <= count_ff - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/scs_control_sequencer.sv ----
// Control-word sequencer and host port of a sync/async serial interface.
// Assumes host strobes and link inputs are synchronous to clk.
// Functional notes
// - Mode word selects synchronous or asynchronous operation for everything after.
// - Sync mode word sets length, parity, parity sense, external sync, sync count.
// - Async mode word sets baud factor x16 or x64, length, parity enable.
// - Sync characters taken only in sync mode; one or two, any value.
// - Command word follows mode/sync; data writes queue, but nothing is sent or received before first command.
// - Command words accepted any time after initialization.
// - Command with bit 6 set returns sequencer to expecting mode word.
// - Mode word changes only after hardware or internal reset.
// - First control write after reset is the mode word.
// - In sync mode the writes after the mode word are sync characters.
// - Second sync skipped for single sync; both skipped in async.
// - After mode and sync, every control write is a command word.
// - Lower address of each pair moves receive and transmit data.
// - Upper address writes control words and reads status.
// - Internal reset command ignores all its other bits.
// - Transmit ready clears on data write; inactive until initialized.
// - Receive ready set on received character, cleared by data read.
// - Async also supports baud factor one for synchronized clocks.
`timescale 1ns/1ps
`default_nettype none
module scs_control_sequencer #(
  parameter int TX_DEPTH = scs_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic transmit_ready_flag,
  output logic receive_ready_flag,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_valid,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic sync_detect,
  input wire logic dsr_in,
  output logic cfg_sync_mode,
  output logic [1:0] cfg_baud_factor,
  output logic [1:0] cfg_char_len,
  output logic cfg_parity_en,
  output logic cfg_parity_even,
  output logic cfg_ext_sync,
  output logic cfg_single_sync,
  output logic [1:0] cfg_stop_bits,
  output logic [7:0] sync_char1,
  output logic [7:0] sync_char2,
  output logic tx_enable,
  output logic rx_enable,
  output logic dtr_out,
  output logic rts_out,
  output logic send_break,
  output logic hunt_enable
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire data_sel = (host_addr == scs_pkg::DATA_ADDR0) || (host_addr == scs_pkg::DATA_ADDR1);
  wire ctrl_sel = (host_addr == scs_pkg::CTRL_ADDR0) || (host_addr == scs_pkg::CTRL_ADDR1);
  wire data_wr = host_wr && data_sel;
  wire data_rd = host_rd && data_sel;
  wire ctrl_wr = host_wr && ctrl_sel;
  wire stat_rd = host_rd && ctrl_sel;

  // ----------------------------------------
  // Control-word sequencer
  // ----------------------------------------
  scs_pkg::scs_seq_type seq_ff;
  scs_pkg::scs_seq_type nxt_seq;
  logic init_ff;

  wire mode_wr = ctrl_wr && (seq_ff == scs_pkg::SEQ_MODE);
  wire sync1_wr = ctrl_wr && (seq_ff == scs_pkg::SEQ_SYNC1);
  wire sync2_wr = ctrl_wr && (seq_ff == scs_pkg::SEQ_SYNC2);
  wire cmd_wr = ctrl_wr && (seq_ff == scs_pkg::SEQ_CMD);
  wire int_reset = cmd_wr && host_wdata[scs_pkg::CMD_INT_RESET];
  wire cmd_take = cmd_wr && !int_reset;
  wire wr_is_sync = (host_wdata[scs_pkg::MODE_BAUD_LSB +: 2] == scs_pkg::BAUD_SYNC);
  wire wr_single = host_wdata[scs_pkg::MODE_SINGLE_SYNC];

  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      scs_pkg::SEQ_MODE: begin
        // Async skips both sync characters
        if (ctrl_wr) nxt_seq = wr_is_sync ? scs_pkg::SEQ_SYNC1 : scs_pkg::SEQ_CMD;
      end
      scs_pkg::SEQ_SYNC1: begin
        if (ctrl_wr) nxt_seq = cfg_single_sync ? scs_pkg::SEQ_CMD : scs_pkg::SEQ_SYNC2;
      end
      scs_pkg::SEQ_SYNC2: begin
        if (ctrl_wr) nxt_seq = scs_pkg::SEQ_CMD;
      end
      scs_pkg::SEQ_CMD: begin
        // A reset during sync entry is taken as a sync character, by design
        if (int_reset) nxt_seq = scs_pkg::SEQ_MODE;
      end
      default: begin
        nxt_seq = scs_pkg::SEQ_MODE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_ff <= scs_pkg::SEQ_MODE;
      init_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      init_ff <= (init_ff || cmd_take) && !int_reset;
    end
  end

  // ----------------------------------------
  // Mode word and sync characters
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_sync_mode <= 1'b0;
      cfg_baud_factor <= scs_pkg::BAUD_SYNC;
      cfg_char_len <= 2'h0;
      cfg_parity_en <= 1'b0;
      cfg_parity_even <= 1'b0;
      cfg_ext_sync <= 1'b0;
      cfg_single_sync <= 1'b0;
      cfg_stop_bits <= 2'h0;
    end else if (mode_wr) begin
      cfg_sync_mode <= wr_is_sync;
      cfg_baud_factor <= host_wdata[scs_pkg::MODE_BAUD_LSB +: 2];
      cfg_char_len <= host_wdata[scs_pkg::MODE_LEN_LSB +: 2];
      cfg_parity_en <= host_wdata[scs_pkg::MODE_PAR_EN];
      cfg_parity_even <= host_wdata[scs_pkg::MODE_PAR_EVEN];
      cfg_ext_sync <= wr_is_sync && host_wdata[scs_pkg::MODE_EXT_SYNC];
      cfg_single_sync <= wr_is_sync && wr_single;
      cfg_stop_bits <= wr_is_sync ? 2'h0 : host_wdata[scs_pkg::MODE_STOP_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_char1 <= scs_pkg::WORD_RESET;
      sync_char2 <= scs_pkg::WORD_RESET;
    end else begin
      if (sync1_wr) sync_char1 <= host_wdata;
      if (sync2_wr) sync_char2 <= host_wdata;
    end
  end

  // ----------------------------------------
  // Command word
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
      send_break <= 1'b0;
      hunt_enable <= 1'b0;
    end else if (int_reset) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
      send_break <= 1'b0;
      hunt_enable <= 1'b0;
    end else if (cmd_take) begin
      tx_enable <= host_wdata[scs_pkg::CMD_TX_EN];
      rx_enable <= host_wdata[scs_pkg::CMD_RX_EN];
      dtr_out <= host_wdata[scs_pkg::CMD_DTR];
      rts_out <= host_wdata[scs_pkg::CMD_RTS];
      send_break <= host_wdata[scs_pkg::CMD_BREAK];
      hunt_enable <= cfg_sync_mode && host_wdata[scs_pkg::CMD_HUNT];
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  // Output stage keeps tx_char registered; drains only while enabled
  // Internal reset drops a parked character rather than send it unconfigured
  wire fifo_out_ready = tx_enable && !int_reset && (!tx_char_valid || tx_char_ready);

  scs_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(data_wr),
    .in_ready(fifo_in_ready),
    .in_data(host_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_char <= scs_pkg::WORD_RESET;
      tx_char_valid <= 1'b0;
    end else if (int_reset) begin
      tx_char_valid <= 1'b0;
    end else begin
      if (fifo_out_ready) tx_char_valid <= fifo_out_valid;
      if (fifo_out_ready && fifo_out_valid) tx_char <= fifo_out_data;
    end
  end

  // Write pulse drops the flag for a cycle even with room left
  wire nxt_tx_rdy = init_ff && tx_enable && fifo_in_ready && !data_wr && !int_reset;
  wire tx_empty = !fifo_out_valid && !tx_char_valid;

  // ----------------------------------------
  // Receive path and status
  // ----------------------------------------
  logic [7:0] rx_hold_ff;
  logic par_err_ff;
  logic ovr_err_ff;
  logic frm_err_ff;
  wire rx_take = rx_char_valid && init_ff && rx_enable && !int_reset;
  wire err_clr = (cmd_take && host_wdata[scs_pkg::CMD_ERR_RST]) || int_reset;
  // Arrival beats the read that clears the flag
  wire nxt_rx_rdy = rx_take || (receive_ready_flag && !data_rd && !int_reset);
  wire [7:0] status_word = {dsr_in, sync_detect, frm_err_ff, ovr_err_ff, par_err_ff,
                            tx_empty, receive_ready_flag, transmit_ready_flag};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_ready_flag <= 1'b0;
      receive_ready_flag <= 1'b0;
      rx_hold_ff <= scs_pkg::WORD_RESET;
      par_err_ff <= 1'b0;
      ovr_err_ff <= 1'b0;
      frm_err_ff <= 1'b0;
    end else begin
      transmit_ready_flag <= nxt_tx_rdy;
      receive_ready_flag <= nxt_rx_rdy;
      if (rx_take) rx_hold_ff <= rx_char;
      par_err_ff <= (rx_take && rx_parity_err) || (par_err_ff && !err_clr);
      ovr_err_ff <= (rx_take && receive_ready_flag && !data_rd) || (ovr_err_ff && !err_clr);
      frm_err_ff <= (rx_take && rx_frame_err) || (frm_err_ff && !err_clr);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= scs_pkg::WORD_RESET;
    end else if (data_rd) begin
      host_rdata <= rx_hold_ff;
    end else if (stat_rd) begin
      host_rdata <= status_word;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  seq_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    int_reset |=> seq_ff == scs_pkg::SEQ_MODE && !init_ff)
    else $error("internal reset did not return to mode state");

  mode_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (seq_ff == scs_pkg::SEQ_MODE && ctrl_wr) |=> cfg_baud_factor == $past(host_wdata[1:0]))
    else $error("first control write not taken as mode");

  sync_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_wr && wr_is_sync) |=> seq_ff == scs_pkg::SEQ_SYNC1 && cfg_sync_mode)
    else $error("sync mode did not expect a sync character");

  async_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_wr && !wr_is_sync) |=> seq_ff == scs_pkg::SEQ_CMD ##1 !cfg_ext_sync)
    else $error("async mode did not skip sync characters");

  single_sync_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sync1_wr && cfg_single_sync) |=> seq_ff == scs_pkg::SEQ_CMD)
    else $error("single sync did not skip second character");

  cmd_stay_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cmd_wr && !host_wdata[scs_pkg::CMD_INT_RESET]) |=> seq_ff == scs_pkg::SEQ_CMD && init_ff)
    else $error("command write left command state");

  ir_ignore_a: assert property (@(posedge clk) disable iff (!arst_n)
    int_reset |=> !tx_enable && !rx_enable && !transmit_ready_flag)
    else $error("internal reset word bits were applied");

  transmit_ready_flag_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    data_wr |=> !transmit_ready_flag)
    else $error("transmit ready not cleared by data write");

  no_init_a: assert property (@(posedge clk) disable iff (!arst_n)
    !init_ff |-> !transmit_ready_flag && !tx_char_valid ##0 !$rose(receive_ready_flag))
    else $error("data path active before first command");

  receive_ready_flag_flow_a: assert property (@(posedge clk) disable iff (!arst_n)
    (data_rd && !rx_take) |=> !receive_ready_flag ##1 (receive_ready_flag || !$past(rx_take)))
    else $error("receive ready did not follow read and arrival");

  stat_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    stat_rd |=> host_rdata == $past(status_word))
    else $error("status read did not return the status word");

  data_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    data_rd |=> host_rdata == $past(rx_hold_ff))
    else $error("data read did not return the received character");

  sync_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    sync1_wr |=> sync_char1 == $past(host_wdata))
    else $error("first sync character not stored");

  cmd_apply_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_take |=> tx_enable == $past(host_wdata[scs_pkg::CMD_TX_EN]) &&
      rx_enable == $past(host_wdata[scs_pkg::CMD_RX_EN]))
    else $error("command enables not applied");

  mode_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !mode_wr |=> $stable(cfg_baud_factor) && $stable(cfg_char_len) && $stable(cfg_sync_mode))
    else $error("mode changed without a mode write");

  transmit_ready_flag_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!init_ff || !tx_enable) |=> !transmit_ready_flag)
    else $error("transmit ready raised before initialization");

  async_clean_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg_sync_mode |-> !cfg_ext_sync && !cfg_single_sync && !hunt_enable)
    else $error("sync-only setting active in async mode");
endmodule
`default_nettype wire

// ---- test/scs_link_model.sv ----
// Serializer stand-in on the link side of the control sequencer.
// Assumes one clock; the bench steers stalls and received characters.
`timescale 1ns/1ps
`default_nettype none
module scs_link_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic stall,
  input wire logic [7:0] tx_char,
  input wire logic tx_char_valid,
  output logic tx_char_ready,
  output logic [7:0] rx_char,
  output logic rx_char_valid,
  output logic rx_parity_err,
  output logic rx_frame_err
);
  logic [7:0] got_q[$];

  assign tx_char_ready = !stall;

  always @(posedge clk) begin
    if (arst_n && tx_char_valid && tx_char_ready) begin
      got_q.push_back(tx_char);
    end
  end

  initial begin
    rx_char = 8'hFF;
    rx_char_valid = 1'b0;
    rx_parity_err = 1'b0;
    rx_frame_err = 1'b0;
  end

  // Idle data is inverted so a stale byte never looks valid
  task automatic send(input logic [7:0] b, input logic perr, input logic ferr);
    rx_char = b;
    rx_char_valid = 1'b1;
    rx_parity_err = perr;
    rx_frame_err = ferr;
    @(posedge clk);
    #1;
    rx_char = ~b;
    rx_char_valid = 1'b0;
    rx_parity_err = 1'b0;
    rx_frame_err = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/scs_control_sequencer_tb.sv ----
// Self-checking bench for the control sequencer and its transmit queue.
// Assumes a link model stands in for the serializer on the far side.
`timescale 1ns/1ps
`default_nettype none
module scs_control_sequencer_tb;
  logic clk, arst_n, host_wr, host_rd, stall, sync_detect, dsr_in;
  logic [7:0] host_addr, host_wdata, host_rdata, tx_char, rx_char, sync_char1, sync_char2;
  logic transmit_ready_flag, receive_ready_flag, tx_char_valid, tx_char_ready;
  logic rx_char_valid, rx_parity_err, rx_frame_err, cfg_sync_mode, cfg_parity_en;
  logic cfg_parity_even, cfg_ext_sync, cfg_single_sync, tx_enable, rx_enable;
  logic dtr_out, rts_out, send_break, hunt_enable;
  logic [1:0] cfg_baud_factor, cfg_char_len, cfg_stop_bits;
  logic [7:0] rd_val;
  int num_errors, num_checks;
  bit ok;

  scs_control_sequencer i_scs_control_sequencer (.clk, .arst_n, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .transmit_ready_flag, .receive_ready_flag,
    .tx_char, .tx_char_valid, .tx_char_ready, .rx_char, .rx_char_valid, .rx_parity_err,
    .rx_frame_err, .sync_detect, .dsr_in, .cfg_sync_mode, .cfg_baud_factor, .cfg_char_len,
    .cfg_parity_en, .cfg_parity_even, .cfg_ext_sync, .cfg_single_sync, .cfg_stop_bits,
    .sync_char1, .sync_char2, .tx_enable, .rx_enable, .dtr_out, .rts_out, .send_break,
    .hunt_enable);

  scs_link_model i_scs_link_model (.clk, .arst_n, .stall, .tx_char, .tx_char_valid,
    .tx_char_ready, .rx_char, .rx_char_valid, .rx_parity_err, .rx_frame_err);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int cycles);
    repeat (cycles) @(posedge clk);
    #1;
  endtask

  // Idle cycle at the end keeps strobes from being rewritten in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    tick(1);
    host_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a);
    host_addr = a;
    host_rd = 1'b1;
    tick(1);
    host_rd = 1'b0;
    tick(1);
    rd_val = host_rdata;
  endtask

  // Bounded status poll; running out of tries counts as a mismatch
  task automatic tx_ready();
    ok = 1'b0;
    for (int k = 0; k < 6 && !ok; k++) begin
      rd(8'hED);
      ok = (rd_val[0] === 1'b1);
    end
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_status();
    dsr_in = 1'b1;
    sync_detect = 1'b1;
    rd(8'hED);
    chk(rd_val & 8'hC7, 8'hC4);
    chk({6'h00, transmit_ready_flag, tx_enable}, 8'h00);
    rd(8'h10);
    chk(rd_val & 8'hC7, 8'hC4);
    wr(8'h11, 8'h00);
    dsr_in = 1'b0;
    sync_detect = 1'b0;
    $display("test reset_status done");
  endtask

  task automatic t_async_init();
    wr(8'hED, 8'h4E);
    chk({cfg_sync_mode, cfg_baud_factor, cfg_char_len, cfg_parity_en, cfg_stop_bits},
        8'h59);
    chk({6'h00, cfg_ext_sync, cfg_single_sync}, 8'h00);
    i_scs_link_model.send(8'h22, 1'b0, 1'b0);
    tick(2);
    chk({6'h00, receive_ready_flag, transmit_ready_flag}, 8'h00);
    wr(8'hED, 8'h05);
    tick(1);
    chk({4'h0, tx_enable, rx_enable, dtr_out, rts_out}, 8'h0C);
    chk({7'h00, transmit_ready_flag}, 8'h01);
    $display("test async_init done");
  endtask

  task automatic t_tx_fifo();
    stall = 1'b1;
    // One character parks in the output stage, the rest fill the queue
    for (int i = 0; i <= scs_pkg::TX_FIFO_DEPTH; i++) begin
      tx_ready();
      host_addr = (i % 2) ? 8'hEE : 8'hEC;
      host_wdata = 8'hA0 + 8'(i);
      host_wr = 1'b1;
      tick(1);
      host_wr = 1'b0;
      chk({7'h00, transmit_ready_flag}, 8'h00);
      tick(1);
    end
    rd(8'hED);
    chk({7'h00, rd_val[0]}, 8'h00);
    stall = 1'b0;
    tick(12);
    chk(8'(i_scs_link_model.got_q.size()), 8'(scs_pkg::TX_FIFO_DEPTH + 1));
    for (int i = 0; i < i_scs_link_model.got_q.size(); i++) begin
      chk(i_scs_link_model.got_q[i], 8'hA0 + 8'(i));
    end
    $display("test tx_fifo done");
  endtask

  task automatic t_receive();
    i_scs_link_model.send(8'h5A, 1'b0, 1'b0);
    chk({7'h00, receive_ready_flag}, 8'h01);
    rd(8'hEE);
    chk(rd_val, 8'h5A);
    chk({7'h00, receive_ready_flag}, 8'h00);
    i_scs_link_model.send(8'h31, 1'b1, 1'b0);
    tick(1);
    i_scs_link_model.send(8'h32, 1'b0, 1'b1);
    tick(1);
    rd(8'hEF);
    chk(rd_val & 8'h3A, 8'h3A);
    rd(8'hEC);
    chk(rd_val, 8'h32);
    wr(8'hED, 8'h15);
    rd(8'hED);
    chk(rd_val & 8'h3A, 8'h00);
    $display("test receive done");
  endtask

  task automatic t_sync_double();
    wr(8'hED, 8'h7F);
    chk({2'h0, tx_enable, rx_enable, dtr_out, rts_out, send_break, hunt_enable},
        8'h00);
    wr(8'hED, 8'h3C);
    chk({cfg_sync_mode, cfg_baud_factor, cfg_char_len, cfg_parity_en, cfg_parity_even,
         cfg_single_sync}, 8'h9E);
    wr(8'hED, 8'h16);
    wr(8'hEF, 8'h17);
    wr(8'hEF, 8'h85);
    chk(sync_char1, 8'h16);
    chk(sync_char2, 8'h17);
    chk({6'h00, hunt_enable, tx_enable}, 8'h03);
    $display("test sync_double done");
  endtask

  task automatic t_sync_single();
    wr(8'hEF, 8'h40);
    wr(8'hEF, 8'hFC);
    chk({5'h00, cfg_ext_sync, cfg_sync_mode, cfg_single_sync}, 8'h07);
    wr(8'hED, 8'h33);
    wr(8'hED, 8'h01);
    chk(sync_char1, 8'h33);
    chk({7'h00, tx_enable}, 8'h01);
    $display("test sync_single done");
  endtask

  // Host abandons init while sync characters are still due
  task automatic t_interrupted();
    wr(8'hED, 8'h40);
    wr(8'hED, 8'h1C);
    repeat (4) wr(8'hED, 8'h00);
    wr(8'hED, 8'h40);
    wr(8'hED, 8'h4D);
    chk({5'h00, cfg_sync_mode, cfg_baud_factor}, 8'h01);
    wr(8'hED, 8'h05);
    chk({7'h00, tx_enable}, 8'h01);
    $display("test interrupted done");
  endtask

  task automatic t_hw_reset();
    arst_n = 1'b0;
    tick(2);
    chk({6'h00, tx_enable, transmit_ready_flag}, 8'h00);
    arst_n = 1'b1;
    wr(8'hED, 8'h4F);
    chk({6'h00, cfg_baud_factor}, 8'h03);
    wr(8'hED, 8'hAE);
    tick(2);
    chk({1'b0, hunt_enable, dtr_out, rts_out, send_break, rx_enable, tx_enable,
         transmit_ready_flag}, 8'h3C);
    $display("test hw_reset done");
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    stall = 1'b0;
    sync_detect = 1'b0;
    dsr_in = 1'b0;
    rd_val = 8'h00;
    num_errors = 0;
    num_checks = 0;
    tick(2);
    arst_n = 1'b1;
    t_reset_status();
    t_async_init();
    t_tx_fifo();
    t_receive();
    t_sync_double();
    t_sync_single();
    t_interrupted();
    t_hw_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
